// ### design/itd_pkg.sv
// Shared constants and types of the instruction timing decoder
package itd_pkg;

  ////////////////////////////////////////////////////////////////
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Execution times in core clock cycles
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;
  localparam logic [2:0] CYC_6 = 3'h6;

  // Flag write masks: bit 0 carry, 1 aux carry, 2 overflow
  localparam logic [2:0] FM_NONE  = 3'h0;
  localparam logic [2:0] FM_CY    = 3'h1;
  localparam logic [2:0] FM_CY_OV = 3'h5;
  localparam logic [2:0] FM_ARITH = 3'h7;

  // Bit space layout
  localparam logic [7:0] BIT_SFR_LIM  = 8'h80;
  localparam logic [3:0] BIT_RAM_BASE = 4'h2;

  // Opcodes watched by timing checks
  localparam logic [7:0] OPC_ADD_DIR = 8'h25;
  localparam logic [7:0] OPC_MUL     = 8'hA4;
  localparam logic [7:0] OPC_DIV     = 8'h84;
  localparam logic [7:0] OPC_DA      = 8'hD4;

  ////////////////////////////////////////////////////////////////
  // Operand space reached by an instruction
  typedef enum logic [2:0] {
    SP_NONE = 3'h0, SP_REG = 3'h1, SP_DIRECT = 3'h2, SP_IND8 = 3'h3,
    SP_XDATA8 = 3'h4, SP_XDATA16 = 3'h5, SP_CODE = 3'h6, SP_BIT = 3'h7
  } itd_space_t;

  // Decoded table entry
  typedef struct packed {
    logic       ok;
    logic [1:0] len;
    logic [2:0] cyc;
    itd_space_t sp;
    logic       xwr;
    logic [2:0] flg;
  } itd_entry_t;

  // Sequencer states, Gray along idle-lookup-execute
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_LOOK = 2'b01, ST_EXEC = 2'b11
  } itd_state_t;

endpackage : itd_pkg

// ### design/itd_dec_if.sv
// Lookup channel between the sequencer and the decode table
`timescale 1ns/1ns
`default_nettype none
interface itd_dec_if import itd_pkg::*; ();
  logic [7:0] opcode;
  logic       req;
  itd_entry_t entry;

  modport rom  (input opcode, input req, output entry);
  modport core (output opcode, output req, input entry);
endinterface : itd_dec_if
`default_nettype wire

// ### design/itd_decode_rom.sv
// Opcode table giving length, cycles, operand space and flags
`timescale 1ns/1ns
`default_nettype none
module itd_decode_rom import itd_pkg::*; (
  input wire logic  core_clk_in,
  input wire logic  rst_n_in,
  itd_dec_if.rom    dif
);

  typedef struct packed {
    itd_entry_t e;
  } itd_rom_st_t;

  itd_rom_st_t s_q;
  itd_rom_st_t s_d;
  logic [3:0]  hi;
  logic [3:0]  lo;

  function automatic itd_entry_t mk(input logic [1:0] l, input logic [2:0] c,
                                    input itd_space_t sp, input logic [2:0] f);
    mk = '{ok: 1'b1, len: l, cyc: c, sp: sp, xwr: 1'b0, flg: f};
  endfunction : mk

  assign hi = dif.opcode[7:4];
  assign lo = dif.opcode[3:0];

  ////////////////////////////////////////////////////////////////
  // Table lookup, taken only on a request
  always_comb
  begin
    s_d = s_q;
    if (dif.req)
    begin
      s_d.e = '0;
      // Accumulator-operand families share one layout
      if (hi inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6, 4'hE} && lo >= 4'h4 && !(hi == 4'hE && lo == 4'h4))
      begin
        if (lo == 4'h4)
          s_d.e = mk(LEN_2, CYC_2, SP_NONE, FM_NONE);
        else if (lo == 4'h5)
          s_d.e = mk(LEN_2, CYC_2, SP_DIRECT, FM_NONE);
        else if (lo[3:1] == 3'h3)
          s_d.e = mk(LEN_1, CYC_2, SP_IND8, FM_NONE);
        else
          s_d.e = mk(LEN_1, CYC_1, SP_REG, FM_NONE);
        if (hi inside {4'h2, 4'h3, 4'h9})
          s_d.e.flg = FM_ARITH;
      end
      else if (hi inside {4'h4, 4'h5, 4'h6} && lo == 4'h2)
        s_d.e = mk(LEN_2, CYC_3, SP_DIRECT, FM_NONE);
      else if (hi inside {4'h4, 4'h5, 4'h6} && lo == 4'h3)
        s_d.e = mk(LEN_3, CYC_3, SP_DIRECT, FM_NONE);
      else if (hi inside {4'h0, 4'h1} && lo >= 4'h8)
        s_d.e = mk(LEN_1, CYC_2, SP_REG, FM_NONE);
      else if (hi inside {4'h0, 4'h1} && lo[3:1] == 3'h3)
        s_d.e = mk(LEN_1, CYC_3, SP_IND8, FM_NONE);
      else if (hi == 4'hF && lo >= 4'h8)
        s_d.e = mk(LEN_1, CYC_1, SP_REG, FM_NONE);
      else if (hi == 4'hA && lo >= 4'h8)
        s_d.e = mk(LEN_2, CYC_3, SP_REG, FM_NONE);
      else if (hi == 4'h7 && lo >= 4'h8)
        s_d.e = mk(LEN_2, CYC_2, SP_REG, FM_NONE);
      else if (hi == 4'h8 && lo >= 4'h8)
        s_d.e = mk(LEN_2, CYC_2, SP_DIRECT, FM_NONE);
      else if (hi == 4'hC && lo >= 4'h8)
        s_d.e = mk(LEN_1, CYC_2, SP_REG, FM_NONE);
      else
      begin
        casez (dif.opcode)
          8'h04, 8'h14, 8'hE4, 8'hF4, 8'h23, 8'h03, 8'hC4, 8'hA3:
            s_d.e = mk(LEN_1, CYC_1, SP_NONE, FM_NONE);
          8'h33, 8'h13, 8'hC3, 8'hD3, 8'hB3:
            s_d.e = mk(LEN_1, CYC_1, SP_NONE, FM_CY);
          8'h05, 8'h15, 8'h85, 8'h75, 8'hC5:
            s_d.e = mk(dif.opcode inside {8'h85, 8'h75} ? LEN_3 : LEN_2, CYC_3, SP_DIRECT, FM_NONE);
          8'h74:
            s_d.e = mk(LEN_2, CYC_2, SP_NONE, FM_NONE);
          8'hF5, 8'hD0:
            s_d.e = mk(LEN_2, CYC_2, SP_DIRECT, FM_NONE);
          8'hC0:
            s_d.e = mk(LEN_2, CYC_3, SP_DIRECT, FM_NONE);
          8'b1000_011?, 8'b1010_011?:
            s_d.e = mk(LEN_2, CYC_3, SP_IND8, FM_NONE);
          8'b1111_011?:
            s_d.e = mk(LEN_1, CYC_2, SP_IND8, FM_NONE);
          8'b0111_011?:
            s_d.e = mk(LEN_2, CYC_2, SP_IND8, FM_NONE);
          8'b1100_011?, 8'b1101_011?:
            s_d.e = mk(LEN_1, CYC_3, SP_IND8, FM_NONE);
          8'hA4, 8'h84:
            s_d.e = mk(LEN_1, dif.opcode == OPC_MUL ? CYC_2 : CYC_6, SP_NONE, FM_CY_OV);
          8'hD4:
            s_d.e = mk(LEN_1, CYC_3, SP_NONE, FM_CY);
          8'h90:
            s_d.e = mk(LEN_3, CYC_3, SP_NONE, FM_NONE);
          8'h93, 8'h83:
            s_d.e = mk(LEN_1, dif.opcode == 8'h93 ? CYC_5 : CYC_4, SP_CODE, FM_NONE);
          8'b1110_001?, 8'b1111_001?:
            s_d.e = mk(LEN_1, dif.opcode[4] ? CYC_5 : CYC_4, SP_XDATA8, FM_NONE);
          8'hE0, 8'hF0:
            s_d.e = mk(LEN_1, dif.opcode[4] ? CYC_4 : CYC_3, SP_XDATA16, FM_NONE);
          8'hC2, 8'hD2, 8'hB2:
            s_d.e = mk(LEN_2, CYC_3, SP_BIT, FM_NONE);
          8'h82, 8'hB0, 8'h72:
            s_d.e = mk(LEN_2, CYC_2, SP_BIT, FM_CY);
          default:
            s_d.e = '0;
        endcase
        if (dif.opcode inside {8'hF0, 8'hF2, 8'hF3})
          s_d.e.xwr = 1'b1;
      end
    end
  end

  // Registered table output
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dif.entry = s_q.e;

endmodule : itd_decode_rom
`default_nettype wire

// ### design/itd_core.sv
// Instruction timing sequencer with operand space decode
// How it works
// - Add: reg 1/1, dir 2/2, ind 1/2, imm 2/2
// - Add with carry uses identical lengths, cycles
// - Subtract with borrow: same four length/cycle pairs
// - Inc/dec: acc 1, reg 2, dir/ind 3
// - Product 2, divide 6, BCD correction 3 cycles
// - Bitwise ops into accumulator, four modes timed
// - Bitwise into direct byte: 2/3, 3/3
// - Accumulator clear, invert, rotates, swap: 1/1
// - Accumulator load: 1/1, 2/2, 1/2, 2/2
// - Bank register write: 1/1, 2/3, 2/2
// - Direct write: 2/2, 3/3, 2/3, 3/3
// - Indirect write: 1/2, 2/3, 2/2
// - Data pointer load: 3 bytes, 3 cycles
// - Code read: 1 byte, 5 or 4 cycles
// - Code space read only, indexed only
// - External data: 1 byte, 4/3 read, 5/4 write
// - External data only via accumulator, indirect
// - Core moves between any RAM/SPECIAL_FUNCTION_REGS locations
// - Push 2/3, pop 2/2
// - Exchanges: 1/2, 2/3, 1/3; low digit 1/3
// - 128 RAM bits plus bit-addressable SFRs
// - Carry ops 1/1, direct bit ops 2/3
// - Bit and/or into carry: 2/2
// - Direct address eight bits, internal only
// - Indirect via bank reg 0/1 or pointer
`timescale 1ns/1ns
`default_nettype none
module itd_core import itd_pkg::*; (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       issue_valid_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic [7:0] bit_addr_in,
  output var  logic       ready_out,
  output var  logic       busy_out,
  output var  logic       done_out,
  output var  logic       illegal_out,
  output var  logic [1:0] length_out,
  output var  logic [2:0] cycles_out,
  output var  logic [2:0] space_out,
  output var  logic       addr16_out,
  output var  logic       ext_write_out,
  output var  logic [2:0] flags_out,
  output var  logic [7:0] bit_byte_out,
  output var  logic [2:0] bit_index_out
);

  ////////////////////////////////////////////////////////////////
  // State of the sequencer
  typedef struct packed {
    itd_state_t st;
    logic [2:0] cnt;
    logic       rdy;
    logic       busy;
    logic       done;
    logic       ill;
    logic [1:0] len;
    logic [2:0] cyc;
    itd_space_t sp;
    logic       a16;
    logic       xwr;
    logic [2:0] flg;
    logic [7:0] bitop;
    logic [7:0] bbyte;
    logic [2:0] bidx;
  } itd_core_st_t;

  itd_core_st_t s_q;
  itd_core_st_t s_d;
  logic         accept;

  itd_dec_if dif ();

  ////////////////////////////////////////////////////////////////
  // Decode table, one cycle of latency
  itd_decode_rom u_rom (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .dif         (dif.rom)
  );

  // Lookup request on an accepted issue
  assign accept     = issue_valid_in && s_q.rdy;
  assign dif.opcode = opcode_in;
  assign dif.req    = accept;

  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.ill  = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (accept)
        begin
          s_d.st    = ST_LOOK;
          s_d.rdy   = 1'b0;
          s_d.bitop = bit_addr_in;
        end
      end
      ST_LOOK:
      begin
        if (!dif.entry.ok)
        begin
          s_d.st  = ST_IDLE;
          s_d.ill = 1'b1;
          s_d.rdy = 1'b1;
        end
        else
        begin
          s_d.st   = ST_EXEC;
          s_d.busy = 1'b1;
          s_d.cnt  = dif.entry.cyc - CYC_1;
          s_d.len  = dif.entry.len;
          s_d.cyc  = dif.entry.cyc;
          s_d.sp   = dif.entry.sp;
          s_d.xwr  = dif.entry.xwr;
          s_d.flg  = dif.entry.flg;
          // Sixteen-bit pointer or code index
          s_d.a16  = dif.entry.sp inside {SP_XDATA16, SP_CODE};
          // Bit number to byte address and bit index
          if (s_q.bitop < BIT_SFR_LIM)
            s_d.bbyte = {BIT_RAM_BASE, s_q.bitop[6:3]};
          else
            s_d.bbyte = {s_q.bitop[7:3], 3'h0};
          s_d.bidx = s_q.bitop[2:0];
        end
      end
      ST_EXEC:
      begin
        if (s_q.cnt == 3'h0)
        begin
          s_d.st   = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.rdy  = 1'b1;
        end
        else
          s_d.cnt = s_q.cnt - CYC_1;
      end
      default:
      begin
        s_d     = '0;
        s_d.rdy = 1'b1;
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign ready_out     = s_q.rdy;
  assign busy_out      = s_q.busy;
  assign done_out      = s_q.done;
  assign illegal_out   = s_q.ill;
  assign length_out    = s_q.len;
  assign cycles_out    = s_q.cyc;
  assign space_out     = s_q.sp;
  assign addr16_out    = s_q.a16;
  assign ext_write_out = s_q.xwr;
  assign flags_out     = s_q.flg;
  assign bit_byte_out  = s_q.bbyte;
  assign bit_index_out = s_q.bidx;

  ////////////////////////////////////////////////////////////////
  // Busy-cycle counter for the checks
  logic [3:0] busy_seen_q;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      busy_seen_q <= 4'h0;
    else if (s_q.busy)
      busy_seen_q <= busy_seen_q + 4'h1;
    else
      busy_seen_q <= 4'h0;
  end

  // Done comes after exactly the listed busy cycles
  a_busy_len_match: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(s_q.done) |-> busy_seen_q == {1'b0, s_q.cyc})
    else $error("busy span differs from cycle count");

  // No new issue taken while executing
  a_no_issue_busy: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_q.busy |-> !s_q.rdy && !dif.req)
    else $error("issue accepted while busy");

  // Multiply runs two cycles
  a_mul_two_cyc: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (accept && opcode_in == OPC_MUL) |-> ##2 s_q.busy ##1 s_q.busy ##1 (s_q.done && !s_q.busy))
    else $error("multiply timing wrong");

  // Divide runs six cycles
  a_div_six_cyc: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (accept && opcode_in == OPC_DIV) |-> ##2 s_q.busy [*6] ##1 s_q.done)
    else $error("divide timing wrong");

  // BCD correction runs three cycles
  a_bcd_three_cyc: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (accept && opcode_in == OPC_DA) |-> ##2 s_q.busy [*3] ##1 s_q.done)
    else $error("bcd correction timing wrong");

  // Add of a direct byte is two bytes, two cycles
  a_add_dir_shape: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (accept && opcode_in == OPC_ADD_DIR) |-> ##2 (s_q.len == LEN_2 && s_q.cyc == CYC_2
      && s_q.sp == SP_DIRECT && s_q.flg == FM_ARITH))
    else $error("direct add shape wrong");

  // External data is one byte via accumulator
  a_xdata_one_byte: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.busy && s_q.sp inside {SP_XDATA8, SP_XDATA16}) |-> s_q.len == LEN_1
      && s_q.cyc >= CYC_3 && s_q.cyc <= CYC_5 && s_q.a16 == (s_q.sp == SP_XDATA16))
    else $error("external data shape wrong");

  // Code space is read only, one byte
  a_code_read_only: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.busy && s_q.sp == SP_CODE) |-> !s_q.xwr && s_q.len == LEN_1
      && (s_q.cyc == CYC_4 || s_q.cyc == CYC_5))
    else $error("code space access wrong");

  // Low bit numbers land in bit RAM bytes
  a_bit_ram_map: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.busy && s_q.bitop < BIT_SFR_LIM) |-> s_q.bbyte[7:4] == BIT_RAM_BASE
      && s_q.bbyte[3:0] == s_q.bitop[6:3])
    else $error("bit RAM mapping wrong");

  // Unknown opcode answers illegal after lookup
  a_illegal_return: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.st == ST_LOOK && !dif.entry.ok) |=> s_q.ill && s_q.rdy && !s_q.busy)
    else $error("unsupported opcode handling wrong");

  // Done is a single-cycle pulse
  a_done_single_pulse: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_q.done |=> !s_q.done)
    else $error("done pulse too long");

  // Done frees the core for the next issue
  a_done_frees_core: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_q.done |-> s_q.rdy && !s_q.busy && s_q.st == ST_IDLE)
    else $error("core not idle with done");

  // An accepted issue drops ready at once
  a_issue_drops_ready: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    accept |=> !s_q.rdy && s_q.st == ST_LOOK)
    else $error("ready still high after issue");

  // External writes only reach external data space
  a_xwr_xdata_only: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_q.xwr |-> s_q.sp inside {SP_XDATA8, SP_XDATA16})
    else $error("external write outside external data");

  // High bit numbers land in bit-addressable register bytes
  a_bit_sfr_map: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.busy && s_q.bitop >= BIT_SFR_LIM) |-> s_q.bbyte == {s_q.bitop[7:3], 3'h0})
    else $error("bit register mapping wrong");

  // Direct operands carry an address byte
  a_direct_two_bytes: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_q.busy && s_q.sp == SP_DIRECT) |-> s_q.len != LEN_1)
    else $error("direct operand without address byte");

  // Sixteen-bit flag follows the operand space
  a_addr16_by_space: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    s_q.busy |-> s_q.a16 == (s_q.sp inside {SP_XDATA16, SP_CODE}))
    else $error("address width flag wrong");

endmodule : itd_core
`default_nettype wire

// ### verification/itd_code_store.sv
// Code store model serving the opcode stream with its timing annotations
`timescale 1ns/1ns
`default_nettype none
module itd_code_store #(
  parameter int DEPTH = 74
) (
  input  wire logic [7:0]  pc_in,
  output var  logic [31:0] word_out
);
  ////////////////////////////////////////////////////////////////
  // Word digits: opcode, bytes, cycles, space (F unchecked), flags, xwr/a16, illegal
  localparam logic [31:0] ROM [0:73] = '{
    32'h2B111700, 32'h00000001, 32'h25222700, 32'h27123700, 32'h24220700,
    32'h3F111700, 32'h36123700, 32'h95222700, 32'h94220700, 32'h9B111700,
    32'h04110000, 32'h08121000, 32'h05232000, 32'h06133000, 32'h1D121000,
    32'h15232000, 32'h17133000, 32'hA3110000, 32'hA4120500, 32'h84160500,
    32'hD4130100, 32'h5A111000, 32'h46123000, 32'h64220000, 32'h55222000,
    32'h52232000, 32'h4333F000, 32'h62232000, 32'hE4110000, 32'hF4110000,
    32'h23110000, 32'h33110100, 32'h03110000, 32'h13110100, 32'hC4110000,
    32'hE9111000, 32'hE5222000, 32'hE6123000, 32'h74220000, 32'hFC111000,
    32'hAA23F000, 32'h7E22F000, 32'hF5222000, 32'h8B22F000, 32'h85332000,
    32'h8723F000, 32'h7533F000, 32'hF6123000, 32'hA723F000, 32'h7622F000,
    32'h90330000, 32'h93156010, 32'h83146010, 32'hE2144000, 32'hE0135010,
    32'hF2154020, 32'hF0145030, 32'hC0232000, 32'hD0222000, 32'hCE121000,
    32'hC5232000, 32'hC7133000, 32'hD6133000, 32'hC3110100, 32'hD3110100,
    32'hB3110100, 32'hC2237000, 32'hD2237000, 32'hB2237000, 32'h82227100,
    32'hB0227100, 32'h72227100, 32'h80000001, 32'hA5000001
  };

  // Read only lookup, indexed by the fetch pointer
  assign word_out = (int'(pc_in) < DEPTH) ? ROM[pc_in] : 32'h00000001;
endmodule : itd_code_store
`default_nettype wire

// ### verification/cpu_instruction_timing_decode_test.sv
// Self-checking bench for the instruction timing decoder
`timescale 1ns/1ns
`default_nettype none
module cpu_instruction_timing_decode_test;
  localparam int NUM_OPS = 74;

  logic        core_clk_in;
  logic        rst_n_in;
  logic        issue_valid;
  logic [7:0]  opcode;
  logic [7:0]  bit_addr;
  logic        ready_out;
  logic        busy_out;
  logic        done_out;
  logic        illegal_out;
  logic [1:0]  length_out;
  logic [2:0]  cycles_out;
  logic [2:0]  space_out;
  logic        addr16_out;
  logic        ext_write_out;
  logic [2:0]  flags_out;
  logic [7:0]  bit_byte_out;
  logic [2:0]  bit_index_out;
  logic [7:0]  pc;
  logic [31:0] word;
  int          fail_count;
  int          compares;
  int          i;
  logic        hung;

  ////////////////////////////////////////////////////////////////
  // Clock, design and code store
  always #5 core_clk_in = ~core_clk_in;

  itd_core DUT (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .issue_valid_in(issue_valid),
    .opcode_in     (opcode),
    .bit_addr_in   (bit_addr),
    .ready_out     (ready_out),
    .busy_out      (busy_out),
    .done_out      (done_out),
    .illegal_out   (illegal_out),
    .length_out    (length_out),
    .cycles_out    (cycles_out),
    .space_out     (space_out),
    .addr16_out    (addr16_out),
    .ext_write_out (ext_write_out),
    .flags_out     (flags_out),
    .bit_byte_out  (bit_byte_out),
    .bit_index_out (bit_index_out)
  );

  itd_code_store #(.DEPTH(NUM_OPS)) store (
    .pc_in   (pc),
    .word_out(word)
  );

  ////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // One issue from the code store, timed against the reference word
  task automatic run_one(input logic refuse);
    logic [31:0] w;
    int          ba;
    int          n;
    int          k;
    w = word;
    ba = $urandom_range(255, 0);
    issue_valid = 1'b1;
    opcode = w[31:24];
    bit_addr = 8'(ba);
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    pc = pc + 8'h01;
    issue_valid = refuse;  // Held high while busy must be ignored
    opcode = 8'h00;
    chk(8'(ready_out), 8'h00);
    n = 0;
    for (k = 0; k < 12 && done_out !== 1'b1 && illegal_out !== 1'b1; k++)
    begin
      @(negedge core_clk_in);
      if (busy_out === 1'b1)
        n++;
    end
    if (k == 12)
    begin
      fail_count++;
      hung = 1'b1;
    end
    else if (w[0])
    begin
      chk(8'(illegal_out), 8'h01);
      chk(8'(n), 8'h00);
    end
    else
    begin
      chk(8'(done_out), 8'h01);
      chk(8'(n), 8'(w[19:16]));
      chk(8'(cycles_out), 8'(w[19:16]));
      chk(8'(length_out), 8'(w[23:20]));
      if (w[15:12] != 4'hF)
        chk(8'(space_out), 8'(w[15:12]));
      chk(8'(flags_out), 8'(w[11:8]));
      chk({6'h00, ext_write_out, addr16_out}, 8'(w[7:4]));
      if (w[15:12] == 4'h7)
      begin
        chk(bit_byte_out, 8'((ba < 128) ? 32 + ba / 8 : (ba / 8) * 8));
        chk(8'(bit_index_out), 8'(ba % 8));
      end
    end
    chk(8'(ready_out), 8'h01);
  endtask : run_one

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    core_clk_in = 1'b0;
    rst_n_in = 1'b0;
    issue_valid = 1'b0;
    opcode = 8'h00;
    bit_addr = 8'h00;
    pc = 8'h00;
    fail_count = 0;
    compares = 0;
    hung = 1'b0;
    void'($urandom(32'hE239));
    repeat (6) @(negedge core_clk_in);
    // Values held in reset
    chk({ready_out, busy_out, done_out, illegal_out, length_out, ext_write_out, addr16_out}, 8'h80);
    chk(8'(cycles_out), 8'h00);
    rst_n_in = 1'b1;
    // Second reset while a divide is executing
    issue_valid = 1'b1;
    opcode = 8'h84;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    issue_valid = 1'b0;
    repeat (2) @(negedge core_clk_in);
    chk(8'(busy_out), 8'h01);
    rst_n_in = 1'b0;
    @(negedge core_clk_in);
    chk({ready_out, busy_out, done_out, illegal_out}, 8'h08);
    rst_n_in = 1'b1;
    // Whole table back to back, first entry with a refused request
    for (i = 0; i < NUM_OPS && !hung; i++)
      run_one(i == 0);
    tally_and_finish();
  end
endmodule : cpu_instruction_timing_decode_test
`default_nettype wire
